// ### hdl/pif_pkg.sv
// Package for the peripheral interrupt flag block: register map, bit positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single 20 MHz system clock.
`default_nettype none
package pif_pkg;
  // Bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_FLAGS1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS2 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE1 = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE2 = 4'hc;
  // Bank one bit positions
  localparam int B1_CONV = 6;
  localparam int B1_RX = 5;
  localparam int B1_TX = 4;
  localparam int B1_SYNC = 3;
  localparam int B1_CCA = 2;
  localparam int B1_PER = 1;
  localparam int B1_OVF = 0;
  // Bank two bit positions
  localparam int B2_OSC = 7;
  localparam int B2_CMPB = 6;
  localparam int B2_CMPA = 5;
  localparam int B2_NVW = 4;
  localparam int B2_BCOL = 3;
  localparam int B2_WAKE = 2;
  localparam int B2_CCB = 0;
  // Implemented-bit masks
  localparam logic [7:0] IMPL1_MASK = 8'h7f;
  localparam logic [7:0] IMPL2_MASK = 8'hfd;
  // Software-writable masks (bank one receive and transmit bits are read-only)
  localparam logic [7:0] WR1_MASK = 8'h4f;
  localparam logic [7:0] WR2_MASK = 8'hfd;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // Capture/compare unit modes
  typedef enum logic [1:0] {CCM_CAPTURE, CCM_COMPARE, CCM_PWM, CCM_OFF} pif_ccmode_t;
  // Synchronous port modes
  typedef enum logic [1:0] {SPM_SPI, SPM_I2C_SLAVE, SPM_I2C_MASTER} pif_spmode_t;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### hdl/pif_flags.sv
// Two banks of peripheral interrupt request flags with enables, over AXI4-Lite.
// Assumes event inputs are one-cycle pulses from logic on clk; levels for buffer states.
//
// Operation
// - Flags set regardless of any enable
// - Bank one bit 7, bank two bit 1 zero
// - Conversion done sets flag, software clears
// - Receive flag mirrors full buffer, read-only
// - Transmit flag high while buffer empty
// - Sync flag on transfer done, all modes
// - Master sequence completion sets sync flag
// - Idle start/stop in multi-master sets flag
// - Capture A on capture/compare, not PWM
// - Period match sets flag until cleared
// - Timer overflow sets flag until cleared
// - Oscillator fail sets flag, software clears
// - Comparator output change sets its flag
// - Nonvolatile write done sets flag
// - I2C master bus collision sets flag
// - Wake-up condition sets flag until cleared
// - Request needs flag, enable, group enable
`default_nettype none
module pif_flags (
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [pif_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [pif_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [pif_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [pif_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral event strobes, buffer and comparator levels, mode selects and group enable
  input wire logic convDone,
  input wire logic rxBufFull,
  input wire logic txBufEmpty,
  input wire logic syncXferDone,
  input wire logic syncSeqDone,
  input wire logic syncIdleStartStop,
  input wire logic syncMultiMaster,
  input wire pif_pkg::pif_spmode_t syncMode,
  input wire logic ccaEvent,
  input wire pif_pkg::pif_ccmode_t ccaMode,
  input wire logic periodMatch,
  input wire logic timerOverflow,
  input wire logic oscFail,
  input wire logic comparatorBOut,
  input wire logic comparatorAOut,
  input wire logic nvWriteDone,
  input wire logic busCollision,
  input wire logic wakeEvent,
  input wire logic ccbEvent,
  input wire pif_pkg::pif_ccmode_t ccbMode,
  input wire logic peripheralGroupEnable,
  // Request to the CPU interrupt logic
  output logic periphIrq
);
  import pif_pkg::*;

  logic [7:0] flags1_q; // Bank one stored flags
  logic [7:0] flags2_q; // Bank two stored flags
  logic [7:0] enable1_q; // Bank one per-bit enables
  logic [7:0] enable2_q; // Bank two per-bit enables
  logic [7:0] set1; // Bank one set pulses
  logic [7:0] set2; // Bank two set pulses
  logic [7:0] view1; // Bank one as read
  logic [7:0] view2; // Bank two as read
  logic cmpA_q; // Previous comparator A output
  logic cmpB_q; // Previous comparator B output
  logic awHeld_q; // Write address captured
  logic wHeld_q; // Write data captured
  logic [ADDR_W-1:0] awAddr_q; // Captured write address
  logic [DATA_W-1:0] wData_q; // Captured write data
  logic wStrb0_q; // Low byte lane strobe
  logic doWrite; // Both halves present, response free
  logic wr1; // Write hits bank one flags
  logic wr2; // Write hits bank two flags

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  ////////////////////////////////////////////////////////////////////////////
  // Comparator edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmpA_q <= 1'b0;
      cmpB_q <= 1'b0;
    end else begin
      cmpA_q <= comparatorAOut;
      cmpB_q <= comparatorBOut;
    end
  end

  // Map events onto set pulses
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[B1_CONV] = convDone;
    set1[B1_SYNC] = syncXferDone
      | (syncSeqDone && syncMode == SPM_I2C_MASTER)
      | (syncIdleStartStop && syncMultiMaster);
    set1[B1_CCA] = ccaEvent && (ccaMode == CCM_CAPTURE || ccaMode == CCM_COMPARE);
    set1[B1_PER] = periodMatch;
    set1[B1_OVF] = timerOverflow;
    set2[B2_OSC] = oscFail;
    set2[B2_CMPB] = comparatorBOut ^ cmpB_q;
    set2[B2_CMPA] = comparatorAOut ^ cmpA_q;
    set2[B2_NVW] = nvWriteDone;
    set2[B2_BCOL] = busCollision && syncMode == SPM_I2C_MASTER;
    set2[B2_WAKE] = wakeEvent;
    set2[B2_CCB] = ccbEvent && (ccbMode == CCM_CAPTURE || ccbMode == CCM_COMPARE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wr1 = doWrite && wStrb0_q && awAddr_q == ADDR_FLAGS1;
  assign wr2 = doWrite && wStrb0_q && awAddr_q == ADDR_FLAGS2;

  // Capture address and data in either order
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb0_q <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_q[1:0] == 2'h0 && awAddr_q <= ADDR_ENABLE2) ? RESP_OKAY
                                                                        : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag storage
  ////////////////////////////////////////////////////////////////////////////
  // set ignores enables; set beats clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags1_q <= FLAGS_RST;
      flags2_q <= FLAGS_RST;
    end else begin
      if (wr1) flags1_q <= ((flags1_q & ~WR1_MASK) | (wData_q[7:0] & flags1_q & WR1_MASK)
                            | set1) & WR1_MASK;
      else flags1_q <= (flags1_q | set1) & WR1_MASK;
      if (wr2) flags2_q <= ((wData_q[7:0] & flags2_q) | set2) & WR2_MASK;
      else flags2_q <= (flags2_q | set2) & WR2_MASK;
    end
  end

  // Per-bit enable registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable1_q <= FLAGS_RST;
      enable2_q <= FLAGS_RST;
    end else if (doWrite && wStrb0_q) begin
      if (awAddr_q == ADDR_ENABLE1) enable1_q <= wData_q[7:0] & IMPL1_MASK;
      if (awAddr_q == ADDR_ENABLE2) enable2_q <= wData_q[7:0] & IMPL2_MASK;
    end
  end

  // Live buffer bits merged into bank one
  always_comb begin
    view1 = flags1_q;
    view1[B1_RX] = rxBufFull;
    view1[B1_TX] = txBufEmpty;
    view1 = view1 & IMPL1_MASK;
    view2 = flags2_q & IMPL2_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_arready = !s_axi_rvalid;

  // Read data and response
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_FLAGS1: s_axi_rdata <= {24'h000000, view1};
        ADDR_FLAGS2: s_axi_rdata <= {24'h000000, view2};
        ADDR_ENABLE1: s_axi_rdata <= {24'h000000, enable1_q};
        ADDR_ENABLE2: s_axi_rdata <= {24'h000000, enable2_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  ////////////////////////////////////////////////////////////////////////////
  // flag, enable and group enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) periphIrq <= 1'b0;
    else periphIrq <= peripheralGroupEnable && |((view1 & enable1_q) | (view2 & enable2_q));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////
  AST_TIMER_SET: assert property (@(posedge clk) disable iff (!reset_n)
    timerOverflow |=> flags1_q[B1_OVF]) else $error("overflow flag not set");
  AST_CONV_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    flags1_q[B1_CONV] && !wr1 |=> flags1_q[B1_CONV]) else $error("conversion flag lost");
  AST_UNIMPL: assert property (@(posedge clk) disable iff (!reset_n)
    !view1[7] && !view2[1]) else $error("unimplemented bit set");
  AST_RX_MIRROR: assert property (@(posedge clk) disable iff (!reset_n)
    view1[B1_RX] == rxBufFull) else $error("receive flag mismatch");
  AST_CCA_PWM: assert property (@(posedge clk) disable iff (!reset_n)
    ccaMode == CCM_PWM && !flags1_q[B1_CCA] |=> !flags1_q[B1_CCA])
    else $error("capture flag set in pwm");
  AST_CMP_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(comparatorAOut) |=> flags2_q[B2_CMPA]) else $error("comparator flag missed");
  AST_BCOL_MODE: assert property (@(posedge clk) disable iff (!reset_n)
    busCollision && syncMode == SPM_I2C_MASTER |=> flags2_q[B2_BCOL])
    else $error("collision flag missed");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!reset_n)
    !peripheralGroupEnable |=> !periphIrq) else $error("request without group enable");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    wr2 && !wData_q[B2_WAKE] && !wakeEvent |=> !flags2_q[B2_WAKE])
    else $error("wake flag not cleared");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
    wr1 && set1[B1_PER] |=> flags1_q[B1_PER]) else $error("set lost to clear");
  AST_OSC_SET: assert property (@(posedge clk) disable iff (!reset_n)
    oscFail |=> flags2_q[B2_OSC]) else $error("oscillator flag not set");
  AST_RD_UPPER: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_rvalid |-> s_axi_rdata[DATA_W-1:8] == '0) else $error("upper read bits set");
endmodule // pif_flags
`default_nettype wire

// ### verif/pif_periph_model.sv
// Stand-in for the on-chip peripherals: turns a fire request into one event strobe.
// Assumes the bench raises fire for one clk cycle with an index below 12.
`default_nettype none
module pif_periph_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fire,
  input wire logic [3:0] fireIdx,
  output logic [11:0] evPulse
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // Event strobes last exactly one clk cycle, as peripheral logic would give
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evPulse <= 12'h000;
    end else begin
      evPulse <= fire ? (12'h001 << fireIdx) : 12'h000;
    end
  end
endmodule // pif_periph_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the interrupt flag block over AXI4-Lite.
// Assumes the peripheral model file and the design package are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pif_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Bus, level and model signals
  logic clk = 1'b0, reset_n = 1'b0;
  logic [3:0] awAddr = 4'h0, arAddr = 4'h0, fireIdx = 4'h0;
  logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, fire = 1'b0;
  logic [31:0] wData = 32'h0, rData, rdData;
  logic awReady, wReady, bValid, arReady, rValid, periphIrq;
  logic [1:0] bResp, rResp, rdResp;
  logic rxFull = 1'b0, txEmpty = 1'b0, cmpA = 1'b0, cmpB = 1'b0, grpEn = 1'b0, multiM = 1'b1;
  pif_spmode_t syncMode = SPM_I2C_MASTER;
  pif_ccmode_t ccaMode = CCM_CAPTURE, ccbMode = CCM_CAPTURE;
  logic [11:0] evPulse;
  logic [3:0] wStrb = 4'hf;
  int nFail = 0, totalChecks = 0;
  int evBit[12] = '{B1_CONV, B1_SYNC, B1_SYNC, B1_SYNC, B1_CCA, B1_PER, B1_OVF,
                    B2_OSC, B2_NVW, B2_BCOL, B2_WAKE, B2_CCB};
  // Clock at 50 ns period
  always #25 clk = ~clk;
  pif_periph_model pif_periph_model_i (.clk(clk), .reset_n(reset_n), .fire(fire),
    .fireIdx(fireIdx), .evPulse(evPulse));
  pif_flags pif_flags_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(1'b1), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
    .convDone(evPulse[0]), .rxBufFull(rxFull), .txBufEmpty(txEmpty),
    .syncXferDone(evPulse[1]), .syncSeqDone(evPulse[2]), .syncIdleStartStop(evPulse[3]),
    .syncMultiMaster(multiM), .syncMode(syncMode), .ccaEvent(evPulse[4]), .ccaMode(ccaMode),
    .periodMatch(evPulse[5]), .timerOverflow(evPulse[6]), .oscFail(evPulse[7]),
    .comparatorBOut(cmpB), .comparatorAOut(cmpA), .nvWriteDone(evPulse[8]),
    .busCollision(evPulse[9]), .wakeEvent(evPulse[10]), .ccbEvent(evPulse[11]),
    .ccbMode(ccbMode), .peripheralGroupEnable(grpEn), .periphIrq(periphIrq));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    if (nFail == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Value comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid);
    check({30'h0, bResp}, {30'h0, er});
  endtask
  // Read: data and response taken at the edge with rvalid high
  task automatic rd(input logic [3:0] a);
    arAddr <= a;
    arValid <= 1'b1;
    do begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid);
    rdData = rData;
    rdResp = rResp;
  endtask
  // One-cycle fire request to the model
  task automatic fire_ev(input int i);
    fireIdx <= 4'(i);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
  endtask
  // Raise an event, read its bank, clear by writing zero, confirm clear
  task automatic ev_check(input int i, input logic [3:0] a, input logic [31:0] e);
    if (i >= 0) fire_ev(i);
    repeat (2) @(posedge clk);
    rd(a);
    check(rdData, e);
    wr(a, 32'h0);
    rd(a);
    check(rdData, 32'h0);
  endtask
  // Request line sampled mid-cycle once settled
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({31'h0, periphIrq}, {31'h0, e});
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4) begin
      rd(4'(a));
      check(rdData, 32'h0);
    end
    // Unmapped word: error response, zero data, no effect
    rd(4'h2);
    check({30'h0, rdResp}, {30'h0, RESP_SLVERR});
    check(rdData, 32'h0);
    wr(4'h2, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 12; i++) begin
      ev_check(i, (i < 7) ? ADDR_FLAGS1 : ADDR_FLAGS2, 32'h1 << evBit[i]);
    end
    cmpA <= ~cmpA;
    ev_check(-1, ADDR_FLAGS2, 32'h1 << B2_CMPA);
    cmpB <= ~cmpB;
    ev_check(-1, ADDR_FLAGS2, 32'h1 << B2_CMPB);
    // Mode gating of capture/compare and port events
    ccaMode <= CCM_COMPARE;
    ccbMode <= CCM_COMPARE;
    ev_check(4, ADDR_FLAGS1, 32'h1 << B1_CCA);
    ev_check(11, ADDR_FLAGS2, 32'h1 << B2_CCB);
    ccaMode <= CCM_PWM;
    ccbMode <= CCM_PWM;
    multiM <= 1'b0;
    ev_check(4, ADDR_FLAGS1, 32'h0);
    ev_check(11, ADDR_FLAGS2, 32'h0);
    ev_check(3, ADDR_FLAGS1, 32'h0);
    syncMode <= SPM_SPI;
    ev_check(2, ADDR_FLAGS1, 32'h0);
    ev_check(9, ADDR_FLAGS2, 32'h0);
    ev_check(1, ADDR_FLAGS1, 32'h1 << B1_SYNC);
    // All flags up with live buffer levels; unimplemented bits stay low
    ccaMode <= CCM_CAPTURE;
    ccbMode <= CCM_CAPTURE;
    syncMode <= SPM_I2C_MASTER;
    for (int i = 0; i < 12; i++) fire_ev(i);
    cmpA <= ~cmpA;
    cmpB <= ~cmpB;
    rxFull <= 1'b1;
    txEmpty <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_FLAGS1);
    check(rdData, 32'h7f);
    rd(ADDR_FLAGS2);
    check(rdData, 32'hfd);
    wr(ADDR_FLAGS2, 32'hff);
    rd(ADDR_FLAGS2);
    check(rdData, 32'hfd);
    wr(ADDR_FLAGS1, 32'h0);
    rd(ADDR_FLAGS1);
    check(rdData, 32'h30);
    rxFull <= 1'b0;
    txEmpty <= 1'b0;
    wr(ADDR_FLAGS2, 32'h0);
    rd(ADDR_FLAGS1);
    check(rdData, 32'h0);
    // Event and clearing write land on one edge: the event wins
    fork
      fire_ev(5);
      wr(ADDR_FLAGS1, 32'h0);
    join
    rd(ADDR_FLAGS1);
    check(rdData, 32'h1 << B1_PER);
    wr(ADDR_FLAGS1, 32'h0);
    rd(ADDR_FLAGS1);
    check(rdData, 32'h0);
    // Enables read back masked; a write without the low lane changes nothing
    wr(ADDR_ENABLE2, 32'hff);
    rd(ADDR_ENABLE2);
    check(rdData, 32'hfd);
    // Request gating: flag, per-bit enable and group enable; flag cleared last
    wr(ADDR_ENABLE1, 32'h1 << B1_OVF);
    wStrb <= 4'he;
    wr(ADDR_ENABLE1, 32'hff);
    rd(ADDR_ENABLE1);
    check(rdData, 32'h1 << B1_OVF);
    wStrb <= 4'hf;
    grpEn <= 1'b1;
    irq_is(1'b0);
    fire_ev(6);
    irq_is(1'b1);
    grpEn <= 1'b0;
    irq_is(1'b0);
    grpEn <= 1'b1;
    irq_is(1'b1);
    wr(ADDR_FLAGS1, 32'h0);
    irq_is(1'b0);
    wr(ADDR_ENABLE2, 32'h1 << B2_CCB);
    fire_ev(11);
    irq_is(1'b1);
    wr(ADDR_FLAGS2, 32'h0);
    irq_is(1'b0);
    complete_run();
  end
endmodule // tb
`default_nettype wire
